/* common/smlpc_pkg.sv */
// Constants and types shared by the lane map and PHY settings block
package smlpc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NUM_LANES     = 8;
	localparam int unsigned NUM_PORTS     = 6;

	typedef enum logic [1:0] {
		MODE_5P5L = 2'h0,
		MODE_6P6L = 2'h1,
		MODE_5P8L = 2'h2,
		MODE_RSVD = 2'h3
	} smlpc_mode_t;

	localparam logic [3:0] SEL_DEFAULT  = 4'h0;
	localparam logic [3:0] SEL_SWAP4    = 4'h1;
	localparam logic [3:0] SEL_SWAP5    = 4'h5;
	localparam logic [3:0] SEL_SWAP6    = 4'h7;
	localparam logic [3:0] SEL_SWAP7    = 4'h9;
	localparam logic [3:0] SEL_P5_LANE0 = 4'h4;

	localparam logic [7:0] OFS_AMP = 8'h74;
	localparam logic [7:0] OFS_DEM = 8'h78;
	localparam logic [7:0] OFS_PHY = 8'h7C;

	localparam logic [1:0] REG_AMP  = 2'h0;
	localparam logic [1:0] REG_DEM  = 2'h1;
	localparam logic [1:0] REG_PHY  = 2'h2;
	localparam logic [1:0] REG_NONE = 2'h3;

	localparam int unsigned AMP_OFFSET_LSB = 0;
	localparam int unsigned AMP_3P5_LSB    = 16;
	localparam int unsigned AMP_6P0_LSB    = 21;
	localparam int unsigned AMP_HALF_LSB   = 26;
	localparam int unsigned DEM_OFFSET_LSB = 0;
	localparam int unsigned DEM_BASE_LSB   = 16;
	localparam int unsigned PHY_TXLAT_LSB  = 0;
	localparam int unsigned PHY_RXDET_LSB  = 4;
	localparam int unsigned PHY_SIGDET_LSB = 20;
	localparam int unsigned PHY_RXEQ_LSB   = 22;
	localparam int unsigned PHY_SWING_BIT  = 30;

	localparam logic [31:0] AMP_MASK = 32'h7FFF_001F;
	localparam logic [31:0] DEM_MASK = 32'h001F_001F;
	localparam logic [31:0] PHY_MASK = 32'h43F0_007F;
	localparam logic [31:0] AMP_RST  = 32'h2210_0000;
	localparam logic [31:0] DEM_RST  = 32'h0008_0000;
	localparam logic [31:0] PHY_RST  = 32'h0190_0020;

	localparam logic [4:0] AMP_MAX_CODE = 5'h13;
	localparam logic [5:0] DEM_MAX_CODE = 6'h3F;

	// Receiver detect wait per code, in ns
	localparam int unsigned RXDET_T_NS [8] = '{1000, 2000, 4000, 5000, 10000, 20000, 40000, 50000};
	localparam int unsigned RXDET_LONGEST_NS = 50000;
	localparam int unsigned RXDET_CNT_W      = 13;

	typedef enum logic [1:0] {
		SC_AMP = 2'b00,
		SC_DEM = 2'b01,
		SC_PHY = 2'b11
	} smlpc_scan_t;
endpackage : smlpc_pkg

/* src/smlpc_cfg_mem.sv */
// Per-port configuration word store with registered read data
module smlpc_cfg_mem #(
	parameter int unsigned ADDR_W = 5,
	parameter int unsigned DATA_W = 32
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              rd_en_in,
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [DATA_W-1:0] rd_data_out
);
	localparam int unsigned DEPTH = 1 << ADDR_W;

	logic [DATA_W-1:0] mem          [DEPTH];
	logic [DATA_W-1:0] next_mem     [DEPTH];
	logic [DATA_W-1:0] next_rd_data;

	// Low two address bits pick the register kind
	function automatic logic [DATA_W-1:0] reset_word(input int unsigned idx);
		case (idx % 4)
			0: reset_word = DATA_W'(smlpc_pkg::AMP_RST);
			1: reset_word = DATA_W'(smlpc_pkg::DEM_RST);
			2: reset_word = DATA_W'(smlpc_pkg::PHY_RST);
			default: reset_word = '0;
		endcase
	endfunction : reset_word

	always_comb
	begin
		next_mem = mem;
		if (wr_en_in)
			next_mem[wr_addr_in] = wr_data_in;
		// Read sees the old word on a same-cycle write
		next_rd_data = rd_en_in ? mem[rd_addr_in] : rd_data_out;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= reset_word(i);
			rd_data_out <= '0;
		end
		else
		begin
			mem         <= next_mem;
			rd_data_out <= next_rd_data;
		end
	end
endmodule : smlpc_cfg_mem

/* src/smlpc_top.sv */
// Lane-to-port mapping from straps and per-lane PHY settings for the switch
// Notes on behaviour
// (R1) Mode straps: 00 five ports/five lanes, 01 six/six, 10 five/eight, 11 reserved.
// (R2) Mode plus upstream lane select give the map; port 0 upstream, 1-5 downstream.
// (R3) Five-lane mode: select 0000 puts port 0 on lane 0; swaps move it to 4-7.
// (R4) Eight-lane mode, select 0000: lanes 0-3 form port 0, lanes 4-7 ports 1-4.
// (R5) Six-lane mode: lane 1 carries port 5; select 0100 swaps lanes 0 and 1.
// (R6) Every lane has its own control and status signals toward the MAC.
// (R7) Amplitude, de-emphasis and equalization are set per port through the config port.
// (R8) Receiver detect samples the far end after 1 to 50 us chosen by 0x7C[6:4].
// (R9) Signal-detect threshold per port from 0x7C[21:20], recommended 01.
// (R10) Receiver equalization per port from 0x7C[25:22], recommended 0110.
// (R11) 0x7C[30] low: full swing with de-emphasis; high: half swing without.
// (R12) Full swing applies a -3.5 dB, or on the lane's 6 dB request a -6 dB, de-emphasis base plus per-channel offset.
// (R13) Swing and de-emphasis condition pick exactly one amplitude base field.
// (R14) Final amplitude and de-emphasis are base plus offset, 25 and 6.25 mV steps.
// (R15) Amplitude bases at 0x74[20:16], [25:21], [30:26]; codes above 10011 reserved.
// (R16) De-emphasis base is 0x78[20:16], codes spanning 0 to 194 mV.
// (R17) Straps are sampled at end of reset; the map holds until next reset.
module smlpc_top #(
	parameter int unsigned RXDET_LONGEST_CYCLES =
		(smlpc_pkg::RXDET_LONGEST_NS + smlpc_pkg::CLK_PERIOD_NS - 1) / smlpc_pkg::CLK_PERIOD_NS
) (
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic [1:0]  mode_strap_in,
	input  wire logic [3:0]  upstream_lane_select_in,
	input  wire logic        cfg_wr_in,
	input  wire logic        cfg_rd_in,
	input  wire logic [2:0]  cfg_port_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [31:0] cfg_wdata_in,
	output logic      [31:0] cfg_rdata_out,
	output logic             cfg_rvalid_out,
	output logic      [1:0]  mode_out,
	output logic             map_valid_out,
	output logic             map_fallback_out,
	output logic      [7:0]  lane_used_out,
	output logic      [23:0] lane_port_out,
	input  wire logic [7:0]  lane_deemph_6db_in,
	input  wire logic [7:0]  lane_rxdet_start_in,
	input  wire logic [7:0]  lane_rxdet_level_in,
	output logic      [7:0]  lane_rxdet_done_out,
	output logic      [7:0]  lane_rxdet_present_out,
	output logic      [15:0] lane_sigdet_thresh_out,
	output logic      [31:0] lane_rx_eq_out,
	output logic      [7:0]  lane_half_swing_out,
	output logic      [39:0] lane_tx_amp_out,
	output logic      [47:0] lane_tx_deemph_out,
	output logic      [31:0] lane_tx_latency_out
);
	localparam int unsigned NL = smlpc_pkg::NUM_LANES;
	localparam int unsigned CW = smlpc_pkg::RXDET_CNT_W;

	logic [5:0]    strap_meta;
	logic [5:0]    strap_sync;
	logic [7:0]    level_meta;
	logic [7:0]    level_sync;
	logic          strap_taken;
	logic          next_strap_taken;
	logic [1:0]    mode_q;
	logic [1:0]    next_mode;
	logic [3:0]    sel_q;
	logic [3:0]    next_sel;
	logic          map_valid_q;
	logic          next_map_valid;
	logic          map_fallback_q;
	logic          next_map_fallback;
	logic [2:0]    lane_port_q       [NL];
	logic [2:0]    next_lane_port    [NL];
	logic [NL-1:0] lane_used_q;
	logic [NL-1:0] next_lane_used;

	function automatic logic [2:0] swap_lane(input logic [3:0] sel);
		case (sel)
			smlpc_pkg::SEL_SWAP4: swap_lane = 3'h4;
			smlpc_pkg::SEL_SWAP5: swap_lane = 3'h5;
			smlpc_pkg::SEL_SWAP6: swap_lane = 3'h6;
			smlpc_pkg::SEL_SWAP7: swap_lane = 3'h7;
			default: swap_lane = 3'h0;
		endcase
	endfunction : swap_lane

	// Returns {used, port}; an unlisted select falls back to the 0000 map
	function automatic logic [3:0] map_lane(input logic [1:0] mode, input logic [3:0] sel,
		input logic [2:0] lane);
		logic [2:0] sw;
		logic [2:0] port;
		logic       used;
		sw   = swap_lane(sel);
		port = 3'h0;
		used = 1'b0;
		if (lane[2])
		begin
			used = (mode != smlpc_pkg::MODE_RSVD);
			port = lane - 3'h3; // see R4
		end
		else if (lane == 3'h0)
			used = (mode != smlpc_pkg::MODE_RSVD);
		else if (lane == 3'h1)
		begin
			used = (mode == smlpc_pkg::MODE_6P6L) || (mode == smlpc_pkg::MODE_5P8L);
			port = (mode == smlpc_pkg::MODE_6P6L) ? 3'h5 : 3'h0;
		end
		else
			used = (mode == smlpc_pkg::MODE_5P8L);
		if ((mode == smlpc_pkg::MODE_5P5L || mode == smlpc_pkg::MODE_6P6L) && sw != 3'h0)
		begin
			if (lane == 3'h0)
				port = sw - 3'h3; // see R3, R5
			else if (lane == sw)
				port = 3'h0;
		end
		if (mode == smlpc_pkg::MODE_6P6L && sel == smlpc_pkg::SEL_P5_LANE0 && lane < 3'h2)
			port = (lane == 3'h0) ? 3'h5 : 3'h0; // see R5
		// Unused lanes report port 0 so nothing downstream mistakes them for a live port
		map_lane = {used, used ? port : 3'h0}; // see R2
	endfunction : map_lane

	function automatic logic sel_known(input logic [1:0] mode, input logic [3:0] sel);
		sel_known = (sel == smlpc_pkg::SEL_DEFAULT)
			|| (mode != smlpc_pkg::MODE_5P8L && swap_lane(sel) != 3'h0)
			|| (mode == smlpc_pkg::MODE_6P6L && sel == smlpc_pkg::SEL_P5_LANE0);
	endfunction : sel_known

	function automatic logic [1:0] reg_index(input logic [7:0] ofs);
		case (ofs)
			smlpc_pkg::OFS_AMP: reg_index = smlpc_pkg::REG_AMP;
			smlpc_pkg::OFS_DEM: reg_index = smlpc_pkg::REG_DEM;
			smlpc_pkg::OFS_PHY: reg_index = smlpc_pkg::REG_PHY;
			default: reg_index = smlpc_pkg::REG_NONE;
		endcase
	endfunction : reg_index

	function automatic logic [31:0] reg_mask(input logic [1:0] idx);
		case (idx)
			smlpc_pkg::REG_AMP: reg_mask = smlpc_pkg::AMP_MASK;
			smlpc_pkg::REG_DEM: reg_mask = smlpc_pkg::DEM_MASK;
			smlpc_pkg::REG_PHY: reg_mask = smlpc_pkg::PHY_MASK;
			default: reg_mask = 32'h0000_0000;
		endcase
	endfunction : reg_mask

	// Base code plus signed 5-bit offset, clamped to 0..lim
	function automatic logic [5:0] add_offset(input logic [4:0] base, input logic [4:0] ofs,
		input logic [5:0] lim);
		logic signed [6:0] sum;
		sum = signed'({2'h0, base}) + signed'({{2{ofs[4]}}, ofs});
		if (sum < 0)
			add_offset = 6'h00;
		else if (sum > signed'({1'h0, lim}))
			add_offset = lim;
		else
			add_offset = sum[5:0];
	endfunction : add_offset

	function automatic logic [CW-1:0] rxdet_wait(input logic [2:0] code);
		if (code == 3'h7)
			rxdet_wait = CW'(RXDET_LONGEST_CYCLES);
		else
			rxdet_wait = CW'((smlpc_pkg::RXDET_T_NS[code] + smlpc_pkg::CLK_PERIOD_NS - 1)
				/ smlpc_pkg::CLK_PERIOD_NS);
	endfunction : rxdet_wait

	// Synchronisers keep running through reset so the straps are settled at release
	always_ff @(posedge clock_in)
	begin
		strap_meta <= {mode_strap_in, upstream_lane_select_in};
		strap_sync <= strap_meta;
		level_meta <= lane_rxdet_level_in;
		level_sync <= level_meta;
	end

	always_comb
	begin
		next_strap_taken  = strap_taken;
		next_mode         = mode_q;
		next_sel          = sel_q;
		next_map_valid    = map_valid_q;
		next_map_fallback = map_fallback_q;
		next_lane_port    = lane_port_q;
		next_lane_used    = lane_used_q;
		// Captured once after release, frozen until the next reset
		if (!strap_taken) // see R17
		begin
			next_strap_taken  = 1'b1;
			next_mode         = strap_sync[5:4]; // see R1
			next_sel          = strap_sync[3:0];
			next_map_valid    = (strap_sync[5:4] != smlpc_pkg::MODE_RSVD);
			next_map_fallback = !sel_known(strap_sync[5:4], strap_sync[3:0]);
			for (int l = 0; l < NL; l++)
				{next_lane_used[l], next_lane_port[l]} =
					map_lane(strap_sync[5:4], strap_sync[3:0], 3'(l)); // see R2
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			strap_taken    <= 1'b0;
			mode_q         <= 2'h0;
			sel_q          <= 4'h0;
			map_valid_q    <= 1'b0;
			map_fallback_q <= 1'b0;
			lane_used_q    <= '0;
			for (int l = 0; l < NL; l++)
				lane_port_q[l] <= 3'h0;
		end
		else
		begin
			strap_taken    <= next_strap_taken;
			mode_q         <= next_mode;
			sel_q          <= next_sel;
			map_valid_q    <= next_map_valid;
			map_fallback_q <= next_map_fallback;
			lane_used_q    <= next_lane_used;
			lane_port_q    <= next_lane_port;
		end
	end

	logic [1:0]  host_idx;
	logic        host_ok;
	logic        host_rd_q;
	logic        host_ok_q;
	logic [31:0] mem_rdata;
	logic [31:0] cfg_rdata_q;
	logic        cfg_rvalid_q;
	logic [31:0] next_cfg_rdata;
	logic        scan_issue;
	logic [1:0]  scan_idx;
	logic [2:0]  scan_lane;
	logic [2:0]  next_scan_lane;

	assign host_idx = reg_index(cfg_addr_in);
	assign host_ok  = (cfg_port_in < 3'(smlpc_pkg::NUM_PORTS)) && (host_idx != smlpc_pkg::REG_NONE);

	// Writes keep only documented fields, so reserved bits read as zero
	smlpc_cfg_mem #(
		.ADDR_W (5),
		.DATA_W (32)
	) u_cfg_mem (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.wr_en_in    (cfg_wr_in && host_ok), // see R7
		.wr_addr_in  ({cfg_port_in, host_idx}),
		.wr_data_in  (cfg_wdata_in & reg_mask(host_idx)),
		.rd_en_in    (cfg_rd_in || scan_issue),
		.rd_addr_in  (cfg_rd_in ? {cfg_port_in, host_idx} : {lane_port_q[scan_lane], scan_idx}),
		.rd_data_out (mem_rdata)
	);

	assign next_cfg_rdata = host_rd_q ? (host_ok_q ? mem_rdata : 32'h0000_0000) : cfg_rdata_q;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			host_rd_q    <= 1'b0;
			host_ok_q    <= 1'b0;
			cfg_rdata_q  <= 32'h0000_0000;
			cfg_rvalid_q <= 1'b0;
		end
		else
		begin
			host_rd_q    <= cfg_rd_in;
			host_ok_q    <= host_ok;
			cfg_rdata_q  <= next_cfg_rdata;
			cfg_rvalid_q <= host_rd_q;
		end
	end

	// Scanner copies each lane's port words into lane shadows; a host read steals the slot
	smlpc_pkg::smlpc_scan_t scan_state;
	smlpc_pkg::smlpc_scan_t next_scan_state;
	logic [2:0]  pend_lane;
	logic [2:0]  next_pend_lane;
	logic        pend_valid;
	logic        next_pend_valid;
	logic [1:0]  pend_reg;
	logic [1:0]  next_pend_reg;
	logic [31:0] scan_amp;
	logic [31:0] next_scan_amp;
	logic [31:0] scan_dem;
	logic [31:0] next_scan_dem;
	logic [31:0] shadow_amp      [NL];
	logic [31:0] next_shadow_amp [NL];
	logic [31:0] shadow_dem      [NL];
	logic [31:0] next_shadow_dem [NL];
	logic [31:0] shadow_phy      [NL];
	logic [31:0] next_shadow_phy [NL];

	always_comb
	begin
		scan_issue = strap_taken && !cfg_rd_in;
		case (scan_state)
			smlpc_pkg::SC_DEM: scan_idx = smlpc_pkg::REG_DEM;
			smlpc_pkg::SC_PHY: scan_idx = smlpc_pkg::REG_PHY;
			default: scan_idx = smlpc_pkg::REG_AMP;
		endcase
		next_scan_state = scan_state;
		next_scan_lane  = scan_lane;
		next_pend_valid = scan_issue;
		next_pend_reg   = scan_idx;
		next_pend_lane  = scan_lane;
		next_scan_amp   = scan_amp;
		next_scan_dem   = scan_dem;
		next_shadow_amp = shadow_amp;
		next_shadow_dem = shadow_dem;
		next_shadow_phy = shadow_phy;
		if (scan_issue)
		begin
			case (scan_state)
				smlpc_pkg::SC_AMP: next_scan_state = smlpc_pkg::SC_DEM;
				smlpc_pkg::SC_DEM: next_scan_state = smlpc_pkg::SC_PHY;
				smlpc_pkg::SC_PHY:
				begin
					next_scan_state = smlpc_pkg::SC_AMP;
					next_scan_lane  = scan_lane + 3'h1;
				end
				default: next_scan_state = smlpc_pkg::SC_AMP;
			endcase
		end
		if (pend_valid)
		begin
			case (pend_reg)
				smlpc_pkg::REG_AMP: next_scan_amp = mem_rdata;
				smlpc_pkg::REG_DEM: next_scan_dem = mem_rdata;
				default:
				begin
					next_shadow_amp[pend_lane] = scan_amp;
					next_shadow_dem[pend_lane] = scan_dem;
					next_shadow_phy[pend_lane] = mem_rdata;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			scan_state <= smlpc_pkg::SC_AMP;
			scan_lane  <= 3'h0;
			pend_lane  <= 3'h0;
			pend_valid <= 1'b0;
			pend_reg   <= smlpc_pkg::REG_AMP;
			scan_amp   <= smlpc_pkg::AMP_RST;
			scan_dem   <= smlpc_pkg::DEM_RST;
			for (int l = 0; l < NL; l++)
			begin
				shadow_amp[l] <= smlpc_pkg::AMP_RST;
				shadow_dem[l] <= smlpc_pkg::DEM_RST;
				shadow_phy[l] <= smlpc_pkg::PHY_RST;
			end
		end
		else
		begin
			scan_state <= next_scan_state;
			scan_lane  <= next_scan_lane;
			pend_lane  <= next_pend_lane;
			pend_valid <= next_pend_valid;
			pend_reg   <= next_pend_reg;
			scan_amp   <= next_scan_amp;
			scan_dem   <= next_scan_dem;
			shadow_amp <= next_shadow_amp;
			shadow_dem <= next_shadow_dem;
			shadow_phy <= next_shadow_phy;
		end
	end

	assign cfg_rdata_out    = cfg_rdata_q;
	assign cfg_rvalid_out   = cfg_rvalid_q;
	assign mode_out         = mode_q;
	assign map_valid_out    = map_valid_q;
	assign map_fallback_out = map_fallback_q;
	assign lane_used_out    = lane_used_q;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	genvar g;
	generate
		for (g = 0; g < NL; g++)
		begin : g_lane
			logic [CW-1:0] cnt;
			logic [CW-1:0] next_cnt;
			logic          busy;
			logic          next_busy;
			logic          done;
			logic          next_done;
			logic          present;
			logic          next_present;
			logic [1:0]    sig;
			logic [1:0]    next_sig;
			logic [3:0]    eq;
			logic [3:0]    next_eq;
			logic          half;
			logic          next_half;
			logic [4:0]    amp;
			logic [4:0]    next_amp;
			logic [5:0]    dem;
			logic [5:0]    next_dem;
			logic [3:0]    lat;
			logic [3:0]    next_lat;
			logic [4:0]    amp_base;

			always_comb
			begin
				next_half = shadow_phy[g][smlpc_pkg::PHY_SWING_BIT]; // see R11
				// Only one base field drives the lane at a time
				if (next_half) // see R13
					amp_base = shadow_amp[g][smlpc_pkg::AMP_HALF_LSB +: 5];
				else if (lane_deemph_6db_in[g])
					amp_base = shadow_amp[g][smlpc_pkg::AMP_6P0_LSB +: 5];
				else
					amp_base = shadow_amp[g][smlpc_pkg::AMP_3P5_LSB +: 5]; // see R12
				next_amp = 5'(add_offset(amp_base, shadow_amp[g][smlpc_pkg::AMP_OFFSET_LSB +: 5],
					{1'h0, smlpc_pkg::AMP_MAX_CODE})); // see R14, R15
				next_dem = next_half ? 6'h00 : add_offset(
					shadow_dem[g][smlpc_pkg::DEM_BASE_LSB +: 5],
					shadow_dem[g][smlpc_pkg::DEM_OFFSET_LSB +: 5], smlpc_pkg::DEM_MAX_CODE); // see R16
				next_sig = shadow_phy[g][smlpc_pkg::PHY_SIGDET_LSB +: 2]; // see R9
				next_eq  = shadow_phy[g][smlpc_pkg::PHY_RXEQ_LSB +: 4]; // see R10
				next_lat = shadow_phy[g][smlpc_pkg::PHY_TXLAT_LSB +: 4];
				next_cnt     = cnt;
				next_busy    = busy;
				next_done    = 1'b0;
				next_present = present;
				// A new start while busy restarts the wait
				if (lane_rxdet_start_in[g] && lane_used_q[g]) // see R6
				begin
					next_busy = 1'b1;
					next_cnt  = rxdet_wait(shadow_phy[g][smlpc_pkg::PHY_RXDET_LSB +: 3]); // see R8
				end
				else if (busy)
				begin
					next_cnt = cnt - 1'h1;
					if (cnt == CW'(1))
					begin
						next_busy    = 1'b0;
						next_done    = 1'b1;
						next_present = level_sync[g];
					end
				end
				if (!lane_used_q[g])
				begin
					{next_half, next_amp, next_dem, next_sig, next_eq, next_lat} = '0;
					next_present = 1'b0;
				end
			end

			always_ff @(posedge clock_in)
			begin
				if (rst_in)
				begin
					{cnt, busy, done, present} <= '0;
					{sig, eq, half, amp, dem, lat} <= '0;
				end
				else
				begin
					{cnt, busy, done, present} <= {next_cnt, next_busy, next_done, next_present};
					{sig, eq, half, amp, dem, lat} <= {next_sig, next_eq, next_half, next_amp,
						next_dem, next_lat};
				end
			end

			assign lane_port_out[g*3 +: 3]          = lane_port_q[g];
			assign lane_rxdet_done_out[g]           = done;
			assign lane_rxdet_present_out[g]        = present;
			assign lane_sigdet_thresh_out[g*2 +: 2] = sig;
			assign lane_rx_eq_out[g*4 +: 4]         = eq;
			assign lane_half_swing_out[g]           = half;
			assign lane_tx_amp_out[g*5 +: 5]        = amp;
			assign lane_tx_deemph_out[g*6 +: 6]     = dem;
			assign lane_tx_latency_out[g*4 +: 4]    = lat;

			sequence s_rxdet_go;
				lane_rxdet_start_in[g] && lane_used_q[g]
					&& shadow_phy[g][smlpc_pkg::PHY_RXDET_LSB +: 3] == 3'h0;
			endsequence
			sequence s_rxdet_quiet;
				!lane_rxdet_start_in[g] throughout ##99 1'b1;
			endsequence
			AST_RXDET_WAIT: assert property (s_rxdet_go ##1 s_rxdet_quiet |=> done) // see R8
				else $error("receiver detect did not finish after 100 cycles");
			AST_RXDET_SAMPLE: assert property (done |-> present == $past(level_sync[g]) || !lane_used_q[g]) // see R8
				else $error("receiver detect result not taken from the synchronised level");
			AST_HALF_NO_DEEMPH: assert property (half |-> dem == 6'h00) // see R11
				else $error("de-emphasis applied in half swing");
			AST_AMP_LIMIT: assert property (amp <= smlpc_pkg::AMP_MAX_CODE) // see R15
				else $error("amplitude beyond the top legal code");
		end
	endgenerate

	AST_MODE_5P5L: assert property (strap_taken && mode_q == smlpc_pkg::MODE_5P5L
		|-> lane_used_q == 8'hF1) // see R1
		else $error("five-lane mode does not use lanes 0 and 4-7");
	AST_508_MAP: assert property (strap_taken && mode_q == smlpc_pkg::MODE_5P8L
		|-> lane_used_q == 8'hFF && lane_port_q[1] == 3'h0 && lane_port_q[7] == 3'h4) // see R4
		else $error("eight-lane map wrong");
	AST_505_SWAP4: assert property (strap_taken && mode_q == smlpc_pkg::MODE_5P5L
		&& sel_q == smlpc_pkg::SEL_SWAP4 |-> lane_port_q[0] == 3'h1 && lane_port_q[4] == 3'h0) // see R3
		else $error("five-lane swap with lane 4 wrong");
	AST_606_P5: assert property (strap_taken && mode_q == smlpc_pkg::MODE_6P6L
		&& sel_q == smlpc_pkg::SEL_P5_LANE0 |-> lane_port_q[0] == 3'h5 && lane_port_q[1] == 3'h0) // see R5
		else $error("six-lane select 0100 map wrong");
	AST_MAP_HOLD: assert property (strap_taken && $past(strap_taken)
		|-> $stable(lane_used_q) && $stable(mode_q)) // see R17
		else $error("lane map changed after capture");
	AST_READ_ANSWER: assert property (cfg_rd_in ##1 !cfg_rd_in |=> cfg_rvalid_out ##1 !cfg_rvalid_out) // see R7
		else $error("config read answer not one cycle two edges later");
endmodule : smlpc_top

/* tb/smlpc_link_model.sv */
// Far-end link partner: receiver termination seen by each lane
module smlpc_link_model (
	input  wire logic       clock_in,
	input  wire logic [7:0] present_in,
	output logic      [7:0] level_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// Termination is a steady level; absent lanes stay low
	always_ff @(posedge clock_in)
		level_out <= present_in;
endmodule : smlpc_link_model

/* tb/tb_top.sv */
// Self-checking bench for the lane map and PHY settings block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rv, mv, fb;
	logic [1:0]  mode = 2'h0, mo;
	logic [3:0]  sel = 4'h0;
	logic [2:0]  port = 3'h0;
	logic [7:0]  addr = 8'h00, used, dm6 = 8'h00, start = 8'h00, lvl, done, pres, hs;
	logic [7:0]  far = 8'h02;
	logic [31:0] wdata = 32'h0, rdata, eq, lat, cnt, rng = 32'h0000_90DA, d, exp_q[$];
	logic [23:0] lp;
	logic [15:0] sd;
	logic [39:0] amp;
	logic [47:0] dem;
	int          n_errors = 0, num_checks = 0;
	logic [1:0]  t_m [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	logic [3:0]  t_s [6] = '{4'h0, 4'h1, 4'h4, 4'h9, 4'h0, 4'h0};
	logic [23:0] t_p [6] = '{24'h8D1000, 24'h8D0001, 24'h8D1005, 24'h0D102C, 24'h8D1000, 24'h0};
	logic [7:0]  t_u [6] = '{8'hF1, 8'hF1, 8'hF3, 8'hF3, 8'hFF, 8'h00};
	logic [7:0]  t_o [3] = '{smlpc_pkg::OFS_AMP, smlpc_pkg::OFS_DEM, smlpc_pkg::OFS_PHY};
	logic [31:0] t_k [3] = '{smlpc_pkg::AMP_MASK, smlpc_pkg::DEM_MASK, smlpc_pkg::PHY_MASK};
	logic [31:0] t_r [3] = '{smlpc_pkg::AMP_RST, smlpc_pkg::DEM_RST, smlpc_pkg::PHY_RST};

	smlpc_top #(.RXDET_LONGEST_CYCLES(50)) dut (.clock_in(clk), .rst_in(rst),
		.mode_strap_in(mode), .upstream_lane_select_in(sel), .cfg_wr_in(wr), .cfg_rd_in(rd),
		.cfg_port_in(port), .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
		.cfg_rvalid_out(rv), .mode_out(mo), .map_valid_out(mv), .map_fallback_out(fb),
		.lane_used_out(used), .lane_port_out(lp), .lane_deemph_6db_in(dm6),
		.lane_rxdet_start_in(start), .lane_rxdet_level_in(lvl), .lane_rxdet_done_out(done),
		.lane_rxdet_present_out(pres), .lane_sigdet_thresh_out(sd), .lane_rx_eq_out(eq),
		.lane_half_swing_out(hs), .lane_tx_amp_out(amp), .lane_tx_deemph_out(dem),
		.lane_tx_latency_out(lat));
	smlpc_link_model far_end (.clock_in(clk), .present_in(far), .level_out(lvl));

	initial
	begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic boot(input logic [1:0] m, input logic [3:0] s);
		@(negedge clk);
		rst = 1'b1;
		mode = m;
		sel = s;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
	endtask : boot

	// Reads note their answer; the monitor pairs it with the next valid pulse
	task automatic acc(input logic w, input logic [2:0] p, input logic [7:0] a,
		input logic [31:0] v, input logic [31:0] e);
		@(negedge clk);
		wr = w;
		rd = !w;
		port = p;
		addr = a;
		wdata = v;
		if (!w)
			exp_q.push_back(e);
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask : acc

	always @(negedge clk)
		if (rv === 1'b1)
		begin
			if (exp_q.size() > 0)
				cmp(rdata, exp_q.pop_front(), "read data");
			else
				cmp(32'h0, 32'h1, "unexpected read answer");
		end

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	initial
	begin
		for (int i = 0; i < 6; i++)
		begin
			boot(t_m[i], t_s[i]);
			cmp({30'h0, mo}, {30'h0, t_m[i]}, "mode");
			cmp({31'h0, mv}, {31'h0, t_m[i] != 2'h3}, "map valid");
			cmp({8'h0, lp}, {8'h0, t_p[i]}, "lane ports");
			cmp({24'h0, used}, {24'h0, t_u[i]}, "lanes used");
			cmp({31'h0, fb}, 32'h0, "no fallback");
			sel = 4'(xs());
			mode = ~mode;
			repeat (5) @(negedge clk);
			cmp({8'h0, lp}, {8'h0, t_p[i]}, "map held");
		end
		// Select not listed for eight-lane mode: default map, fallback flagged
		boot(2'h2, 4'h1);
		cmp({31'h0, fb}, 32'h1, "fallback");
		cmp({8'h0, lp}, 32'h008D_1000, "fallback map");
		for (int r = 0; r < 3; r++)
		begin
			acc(1'b0, 3'(r * 2), t_o[r], 32'h0, t_r[r]);
			d = xs();
			acc(1'b1, 3'h1, t_o[r], d, 32'h0);
			acc(1'b0, 3'h1, t_o[r], 32'h0, d & t_k[r]);
		end
		acc(1'b0, 3'h6, smlpc_pkg::OFS_PHY, 32'h0, 32'h0);
		acc(1'b0, 3'h0, 8'h70, 32'h0, 32'h0);
		// Half swing, high eq, top threshold, shortest detect wait, latency 5
		acc(1'b1, 3'h0, smlpc_pkg::OFS_PHY, 32'h43B0_0005, 32'h0);
		acc(1'b1, 3'h0, smlpc_pkg::OFS_AMP, 32'h1400_0000, 32'h0);
		dm6 = 8'(xs());
		repeat (40) @(negedge clk);
		cmp({28'h0, eq[11:8]}, 32'hE, "rx eq");
		cmp({30'h0, sd[5:4]}, 32'h3, "sigdet");
		cmp({31'h0, hs[2]}, 32'h1, "half swing");
		cmp({26'h0, dem[17:12]}, 32'h0, "no deemph");
		cmp({27'h0, amp[19:15]}, 32'h5, "half amp");
		cmp({28'h0, lat[11:8]}, 32'h5, "tx latency");
		start = 8'h02;
		@(negedge clk);
		start = 8'h00;
		cnt = 0;
		while (done[1] !== 1'b1 && cnt < 200)
		begin
			@(negedge clk);
			cnt++;
		end
		cmp(cnt, smlpc_pkg::RXDET_T_NS[0] / smlpc_pkg::CLK_PERIOD_NS, "detect wait");
		cmp({31'h0, pres[1]}, 32'h1, "present");
		@(negedge clk);
		cmp({31'h0, done[1]}, 32'h0, "done pulse");
		cmp(exp_q.size(), 32'h0, "answers left");
		end_of_test();
	end
endmodule : tb_top
